// [src/lhci_core.sv]
// Behaviour
// - cs, rd low, wr high, cd high: drive status byte onto data lines.
// - cd high means command or status; low means operand or display data.
// - bit0 command ready, bit1 data ready; zero when not ready.
// - bit2 auto read ready, bit3 auto write ready.
// - bit5 shows controller running; bit4 unused reads zero.
// - bit6 set when peek or copy fails; held until the next peek or copy command clears it.
// - bit7 zero in blink off phase, one in normal display.
// - in auto mode bits 2 and 3 are valid, bits 0 and 1 not.
// - msb-zero commands may wait for end of line; host polls status.
// - with surplus operands only the last one or two bytes count.
// - 21h loads cursor column then row; cursor never steps by itself.
// - cursor column keeps 7 bits, row keeps 5 bits.
// - 22h loads 5-bit bank select, forming cg address bits 15..11.
// - cg address bits 10..3 from code, bits 2..0 from row counter.
// - 24h loads 16-bit ram pointer, low byte first.
// - 40h text base, 42h graphic base, low byte then high byte.
// - 41h and 43h load text and graphic row stride.
// - mode low bits: 000 or, 001 xor, 011 and, 100 attribute; kept.
// - mode bit3 selects external cg; internal mode sends 80h+ to ram.
// - attribute mode reads nth attribute from nth graphic byte, text only.
// - attribute bits 2..0 decode normal, reverse, inhibit, bit3 blinks.
module lhci_core
   import lhci_pkg::*;
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  clk_en_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  rd_n_in,
   input  wire logic                  wr_n_in,
   input  wire logic                  cd_in,
   input  wire logic [7:0]            data_in,
   input  wire logic                  line_end_in,
   input  wire logic                  blink_off_in,
   input  wire logic                  peek_fail_in,
   input  wire logic [7:0]            char_code_in,
   input  wire logic [2:0]            row_count_in,
   input  wire logic [7:0]            attr_byte_in,
   output logic      [7:0]            data_out,
   output logic                       data_oe_out,
   output logic      [15:0]           cg_addr_out,
   output logic                       cg_external_out,
   output logic      [15:0]           attr_addr_out,
   output logic      [2:0]            combine_mode_out,
   output logic                       graphic_shown_out,
   output logic                       attr_reverse_out,
   output logic                       attr_inhibit_out,
   output logic                       attr_blink_out,
   output lhci_pkg::lhci_regs_t       regs_out
);
   import lhci_pkg::*;

   typedef struct packed {
      lhci_bus_t   sync1;
      lhci_bus_t   sync2;
      logic        wr_act;
      logic [7:0]  op_last;
      logic [7:0]  op_prev;
      lhci_state_t state;
      logic [1:0]  exec_cnt;
      logic        auto_rd;
      logic        err;
      lhci_regs_t  regs;
      logic [7:0]  dout;
      logic        oe;
      logic [15:0] cg_addr;
      logic        cg_ext;
      logic [15:0] attr_addr;
      lhci_attr_t  attr;
      logic [2:0]  combine;
      logic        shown;
      logic        blink_in1;
      logic        blink_in2;
      logic        line_in1;
      logic        line_in2;
      logic        fail_in1;
      logic        fail_in2;
   } lhci_core_t;

   lhci_core_t st_ff;
   lhci_core_t nxt_st;
   lhci_bus_t  bus_now;
   logic [7:0] status_byte;
   logic       wr_end;
   logic [7:0] cmd;

   assign bus_now = '{cs_n: cs_n_in, rd_n: rd_n_in, wr_n: wr_n_in, cd: cd_in, data: data_in};

   always_comb
   begin
      nxt_st = st_ff;
      cmd    = st_ff.sync2.data;
      // two-flop pin synchronisers
      nxt_st.sync1     = bus_now;
      nxt_st.sync2     = st_ff.sync1;
      nxt_st.blink_in1 = blink_off_in;
      nxt_st.blink_in2 = st_ff.blink_in1;
      nxt_st.line_in1  = line_end_in;
      nxt_st.line_in2  = st_ff.line_in1;
      nxt_st.fail_in1  = peek_fail_in;
      nxt_st.fail_in2  = st_ff.fail_in1;

      // write active while cs and wr low; byte taken on rising wr
      nxt_st.wr_act = !st_ff.sync2.cs_n && !st_ff.sync2.wr_n;
      wr_end = st_ff.wr_act && st_ff.sync2.wr_n;

      // status byte
      status_byte               = 8'h00;
      status_byte[ST_CMD_OK]    = (st_ff.state == LHCI_IDLE);
      status_byte[ST_DATA_OK]   = (st_ff.state == LHCI_IDLE);
      status_byte[ST_AREAD_OK]  = (st_ff.state == LHCI_AUTO) && st_ff.auto_rd;
      status_byte[ST_AWRITE_OK] = (st_ff.state == LHCI_AUTO) && !st_ff.auto_rd;
      status_byte[ST_SPARE]     = 1'b0;
      status_byte[ST_RUN]       = 1'b1;
      status_byte[ST_ERR]       = st_ff.err;
      status_byte[ST_BLINK]     = !st_ff.blink_in2;

      // status read with cd high, data read otherwise floats
      nxt_st.oe   = !st_ff.sync2.cs_n && !st_ff.sync2.rd_n
                    && st_ff.sync2.wr_n && st_ff.sync2.cd;
      nxt_st.dout = status_byte;

      case (st_ff.state)
         LHCI_IDLE:
         begin
            if (wr_end && !st_ff.sync2.cd)
            begin
               nxt_st.op_prev = st_ff.op_last;
               nxt_st.op_last = st_ff.sync2.data;
            end
            else if (wr_end && st_ff.sync2.cd)
            begin
               if (cmd == CMD_CURSOR_SET)
               begin
                  nxt_st.regs.cursor_column = st_ff.op_prev[COL_W-1:0];
                  nxt_st.regs.cursor_row    = st_ff.op_last[ROW_W-1:0];
               end
               if (cmd == CMD_BANK_SET)
                  nxt_st.regs.cg_bank_bits = st_ff.op_prev[BANK_W-1:0];
               if (cmd == CMD_POINTER_SET)
                  nxt_st.regs.ram_access_pointer = {st_ff.op_last, st_ff.op_prev};
               if (cmd == CMD_TEXT_BASE)
                  nxt_st.regs.text_base = {st_ff.op_last, st_ff.op_prev};
               if (cmd == CMD_GFX_BASE)
                  nxt_st.regs.graphic_base = {st_ff.op_last, st_ff.op_prev};
               if (cmd == CMD_TEXT_STRIDE)
                  nxt_st.regs.text_stride = st_ff.op_prev;
               if (cmd == CMD_GFX_STRIDE)
                  nxt_st.regs.graphic_stride = st_ff.op_prev;
               if (cmd[7:4] == CMD_MODE_HI)
                  nxt_st.regs.mode = cmd[3:0];
               if (cmd == CMD_PEEK || cmd == CMD_COPY)
                  nxt_st.err = 1'b0;
               if (cmd == CMD_AUTO_WRITE || cmd == CMD_AUTO_READ)
               begin
                  nxt_st.auto_rd = (cmd == CMD_AUTO_READ);
                  nxt_st.state   = LHCI_AUTO;
               end
               else if (!cmd[7])
                  nxt_st.state = LHCI_PENDING;
               else
               begin
                  nxt_st.exec_cnt = 2'(EXEC_CYCLES - 1);
                  nxt_st.state    = LHCI_EXEC;
               end
            end
         end
         LHCI_EXEC:
         begin
            if (st_ff.exec_cnt == 2'h0)
               nxt_st.state = LHCI_IDLE;
            else
               nxt_st.exec_cnt = st_ff.exec_cnt - 2'h1;
         end
         LHCI_PENDING:
         begin
            // bytes written while pending are ignored
            if (st_ff.line_in2)
               nxt_st.state = LHCI_IDLE;
         end
         LHCI_AUTO:
         begin
            if (wr_end && st_ff.sync2.cd && cmd == CMD_AUTO_RESET)
               nxt_st.state = LHCI_IDLE;
            else if (wr_end && !st_ff.sync2.cd)
               nxt_st.regs.ram_access_pointer = st_ff.regs.ram_access_pointer + 16'h0001;
         end
         default:
            nxt_st.state = LHCI_IDLE;
      endcase

      // failure set wins over clear
      if (st_ff.fail_in2)
         nxt_st.err = 1'b1;

      // cg address composition
      nxt_st.cg_ext = st_ff.regs.mode[MODE_EXT_CG_BIT] || (char_code_in > INT_CG_LAST);
      nxt_st.cg_addr = {st_ff.regs.cg_bank_bits, char_code_in, row_count_in};

      // attribute decode
      nxt_st.attr_addr = st_ff.regs.graphic_base + 16'(st_ff.regs.ram_access_pointer
                         - st_ff.regs.text_base);
      nxt_st.attr.reverse = (attr_byte_in[2:0] == ATTR_REVERSE);
      nxt_st.attr.inhibit = (attr_byte_in[2:0] == ATTR_INHIBIT);
      nxt_st.attr.blink   = attr_byte_in[ATTR_BLINK_BIT];
      if (st_ff.regs.mode[2:0] != MODE_ATTR)
         nxt_st.attr = '0;
      // layer outputs registered with the attribute decode
      nxt_st.combine = st_ff.regs.mode[2:0];
      nxt_st.shown   = (st_ff.regs.mode[2:0] != MODE_ATTR);
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         st_ff       <= '0;
         st_ff.sync1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cd: 1'b0, data: 8'h00};
         st_ff.sync2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cd: 1'b0, data: 8'h00};
         st_ff.state <= LHCI_IDLE;
         st_ff.shown <= 1'b1;
         st_ff.regs  <= '{cursor_column: '0, cursor_row: '0, cg_bank_bits: '0,
                          ram_access_pointer: RST_WORD, text_base: RST_WORD,
                          text_stride: RST_STRIDE, graphic_base: RST_WORD,
                          graphic_stride: RST_STRIDE, mode: RST_MODE};
      end
      else if (clk_en_in)
         st_ff <= nxt_st;
   end

   assign data_out          = st_ff.dout;
   assign data_oe_out       = st_ff.oe;
   assign cg_addr_out       = st_ff.cg_addr;
   assign cg_external_out   = st_ff.cg_ext;
   assign attr_addr_out     = st_ff.attr_addr;
   assign combine_mode_out  = st_ff.combine;
   assign graphic_shown_out = st_ff.shown;
   assign attr_reverse_out  = st_ff.attr.reverse;
   assign attr_inhibit_out  = st_ff.attr.inhibit;
   assign attr_blink_out    = st_ff.attr.blink;
   assign regs_out          = st_ff.regs;

endmodule

// [src/lhci_pkg.sv]
package lhci_pkg;

   // command codes
   localparam logic [7:0] CMD_CURSOR_SET   = 8'h21;
   localparam logic [7:0] CMD_BANK_SET     = 8'h22;
   localparam logic [7:0] CMD_POINTER_SET  = 8'h24;
   localparam logic [7:0] CMD_TEXT_BASE    = 8'h40;
   localparam logic [7:0] CMD_TEXT_STRIDE  = 8'h41;
   localparam logic [7:0] CMD_GFX_BASE     = 8'h42;
   localparam logic [7:0] CMD_GFX_STRIDE   = 8'h43;
   localparam logic [3:0] CMD_MODE_HI      = 4'h8;
   localparam logic [7:0] CMD_AUTO_WRITE   = 8'hB0;
   localparam logic [7:0] CMD_AUTO_READ    = 8'hB1;
   localparam logic [7:0] CMD_AUTO_RESET   = 8'hB2;
   localparam logic [7:0] CMD_PEEK         = 8'hE0;
   localparam logic [7:0] CMD_COPY         = 8'hE8;

   // status bit positions
   localparam int ST_CMD_OK   = 0;
   localparam int ST_DATA_OK  = 1;
   localparam int ST_AREAD_OK = 2;
   localparam int ST_AWRITE_OK = 3;
   localparam int ST_SPARE    = 4;
   localparam int ST_RUN      = 5;
   localparam int ST_ERR      = 6;
   localparam int ST_BLINK    = 7;

   // field widths and positions
   localparam int COL_W        = 7;
   localparam int ROW_W        = 5;
   localparam int BANK_W       = 5;
   localparam int CG_CODE_LSB  = 3;
   localparam int CG_BANK_LSB  = 11;

   // combine modes (low mode bits)
   localparam logic [2:0] MODE_OR   = 3'h0;
   localparam logic [2:0] MODE_XOR  = 3'h1;
   localparam logic [2:0] MODE_AND  = 3'h3;
   localparam logic [2:0] MODE_ATTR = 3'h4;
   localparam int MODE_EXT_CG_BIT   = 3;
   localparam logic [7:0] INT_CG_LAST = 8'h7F;

   // attribute codes
   localparam logic [2:0] ATTR_NORMAL  = 3'h0;
   localparam logic [2:0] ATTR_REVERSE = 3'h5;
   localparam logic [2:0] ATTR_INHIBIT = 3'h3;
   localparam int ATTR_BLINK_BIT       = 3;

   // reset values
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [7:0]  RST_STRIDE = 8'h00;
   localparam logic [3:0]  RST_MODE   = 4'h0;

   // timing: execute window of msb-one commands other than B0h and B1h before return to idle
   localparam int EXEC_CYCLES = 2;

   typedef enum logic [3:0] {
      LHCI_IDLE    = 4'b0001,
      LHCI_EXEC    = 4'b0010,
      LHCI_PENDING = 4'b0100,
      LHCI_AUTO    = 4'b1000
   } lhci_state_t;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       cd;
      logic [7:0] data;
   } lhci_bus_t;

   typedef struct packed {
      logic [COL_W-1:0]  cursor_column;
      logic [ROW_W-1:0]  cursor_row;
      logic [BANK_W-1:0] cg_bank_bits;
      logic [15:0]       ram_access_pointer;
      logic [15:0]       text_base;
      logic [7:0]        text_stride;
      logic [15:0]       graphic_base;
      logic [7:0]        graphic_stride;
      logic [3:0]        mode;
   } lhci_regs_t;

   typedef struct packed {
      logic       reverse;
      logic       inhibit;
      logic       blink;
   } lhci_attr_t;

endpackage

// [tb/lhci_chk.sv]
module lhci_chk
   import lhci_pkg::*;
(
   input wire logic                 sys_clk_in,
   input wire logic                 rst_in,
   input wire logic                 clk_en_in,
   input wire logic                 cs_n_in,
   input wire logic                 rd_n_in,
   input wire logic                 wr_n_in,
   input wire logic                 cd_in,
   input wire logic [7:0]           char_code_in,
   input wire logic [2:0]           row_count_in,
   input wire logic [7:0]           attr_byte_in,
   input wire logic [7:0]           data_out,
   input wire logic                 data_oe_out,
   input wire logic [15:0]          cg_addr_out,
   input wire logic                 cg_external_out,
   input wire logic [15:0]          attr_addr_out,
   input wire logic [2:0]           combine_mode_out,
   input wire logic                 graphic_shown_out,
   input wire logic                 attr_reverse_out,
   input wire logic                 attr_inhibit_out,
   input wire logic                 attr_blink_out,
   input wire lhci_pkg::lhci_regs_t regs_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_st;
   assign rd_st = !cs_n_in && !rd_n_in && wr_n_in && cd_in;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in || !clk_en_in);
   chk_oe_on: assert property (rd_st [*5] |-> data_oe_out)
      else $error("status not driven");
   chk_oe_off: assert property (!rd_st [*5] |-> !data_oe_out)
      else $error("status driven without read");
   chk_fixed_bits: assert property (data_oe_out |-> !data_out[ST_SPARE] && data_out[ST_RUN])
      else $error("spare or run bit wrong");
   chk_cg_addr: assert property ($stable(char_code_in) && $stable(row_count_in)
      && $stable(regs_out.cg_bank_bits) |=> cg_addr_out ==
      {$past(regs_out.cg_bank_bits), $past(char_code_in), $past(row_count_in)})
      else $error("cg address wrong");
   chk_cg_source: assert property ($stable(char_code_in) && $stable(regs_out.mode)
      |=> cg_external_out == ($past(regs_out.mode[3]) || $past(char_code_in[7])))
      else $error("cg source wrong");
   chk_mode_out: assert property ($stable(regs_out.mode)
      |=> combine_mode_out == $past(regs_out.mode[2:0]))
      else $error("combine mode wrong");
   chk_attr_quiet: assert property ($stable(regs_out.mode) && regs_out.mode[2:0] != MODE_ATTR
      |=> graphic_shown_out && !attr_reverse_out && !attr_inhibit_out && !attr_blink_out)
      else $error("attribute outputs active outside attribute mode");
   chk_attr_decode: assert property ($stable(attr_byte_in) && $stable(regs_out.mode)
      && regs_out.mode[2:0] == MODE_ATTR |=> !graphic_shown_out
      && attr_blink_out == $past(attr_byte_in[ATTR_BLINK_BIT])
      && attr_reverse_out == ($past(attr_byte_in[2:0]) == ATTR_REVERSE)
      && attr_inhibit_out == ($past(attr_byte_in[2:0]) == ATTR_INHIBIT))
      else $error("attribute decode wrong");
   chk_attr_addr: assert property ($stable(regs_out) |=> attr_addr_out ==
      16'($past(regs_out.graphic_base) + $past(regs_out.ram_access_pointer)
      - $past(regs_out.text_base)))
      else $error("attribute address wrong");
   cov_read: cover property (rd_st [*5]);
   cov_attr: cover property (regs_out.mode[2:0] == MODE_ATTR);
   cov_ext: cover property (cg_external_out);
endmodule
bind lhci_core lhci_chk chk_u (.sys_clk_in, .rst_in, .clk_en_in, .cs_n_in, .rd_n_in, .wr_n_in,
   .cd_in, .char_code_in, .row_count_in, .attr_byte_in, .data_out, .data_oe_out, .cg_addr_out,
   .cg_external_out, .combine_mode_out, .graphic_shown_out, .attr_reverse_out,
   .attr_inhibit_out, .attr_blink_out, .attr_addr_out, .regs_out);

// [tb/lhci_host.sv]
module lhci_host
   import lhci_pkg::*;
(
   input  wire logic                sys_clk_in,
   input  wire logic [7:0]          st_in,
   input  wire logic                st_oe_in,
   output lhci_pkg::lhci_bus_t      bus_out
);
   timeunit 1ns;
   timeprecision 1ns;
   lhci_bus_t  b = {4'hF, 8'hA5};
   logic [7:0] st = 8'h00;
   logic       auto_on = 1'b0;
   event       seen;
   assign bus_out = b;
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   task automatic rd();
      b.cs_n = 1'b0;
      b.rd_n = 1'b0;
      b.cd = 1'b1;
      hold(5);
      st = st_oe_in ? st_in : 8'h00;
      -> seen;
      b.cs_n = 1'b1;
      b.rd_n = 1'b1;
      b.data = ~b.data;
      hold(3);
   endtask
   // poll instead of a fixed delay
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         rd();
         n++;
      end
      while (!(auto_on ? |st[3:2] : &st[1:0]) && n < 60);
   endtask
   task automatic wr(input logic cd, input logic [7:0] v, input logic sel_n);
      wait_ready();
      b.cs_n = sel_n;
      b.cd = cd;
      b.data = v;
      hold(1);
      b.wr_n = 1'b0;
      hold(4);
      b.wr_n = 1'b1;
      hold(4);
      b.cs_n = 1'b1;
      b.data = ~v;
      hold(3);
   endtask
endmodule

// [tb/lhci_core_tb.sv]
module lhci_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lhci_pkg::*;
   logic       sys_clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       clk_en = 1'b1;
   logic       line_end = 1'b0;
   logic       blink_off = 1'b0;
   logic       peek_fail = 1'b0;
   logic [7:0] code = 8'h00;
   logic [7:0] attr = 8'h00;
   logic [2:0] row = 3'h0;
   logic [7:0] dout;
   logic       doe;
   lhci_bus_t  hb;
   lhci_regs_t regs, er, eg;
   logic [31:0] seed = 32'hBAFB;
   logic [31:0] r;
   logic [7:0] c, o1, o2;
   logic [8:0] es;
   int         cyc = 0;
   int         miscompares = 0;
   int         n_checks = 0;
   logic [8:0] sq[$];
   lhci_regs_t rq[$];
   event       reg_ev;
   logic [7:0] codes[7] = '{CMD_CURSOR_SET, CMD_BANK_SET, CMD_POINTER_SET, CMD_TEXT_BASE,
      CMD_TEXT_STRIDE, CMD_GFX_BASE, CMD_GFX_STRIDE};
   logic [3:0] modes[8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8, 4'h9, 4'hB, 4'hC};
   lhci_core dut_u (.sys_clk_in, .rst_in, .clk_en_in(clk_en), .cs_n_in(hb.cs_n),
      .rd_n_in(hb.rd_n), .wr_n_in(hb.wr_n), .cd_in(hb.cd), .data_in(hb.data),
      .line_end_in(line_end), .blink_off_in(blink_off), .peek_fail_in(peek_fail),
      .char_code_in(code), .row_count_in(row), .attr_byte_in(attr), .data_out(dout),
      .data_oe_out(doe), .cg_addr_out(), .cg_external_out(), .attr_addr_out(),
      .combine_mode_out(), .graphic_shown_out(), .attr_reverse_out(), .attr_inhibit_out(),
      .attr_blink_out(), .regs_out(regs));
   lhci_host host_u (.sys_clk_in, .st_in(dout), .st_oe_in(doe), .bus_out(hb));
   always #10 sys_clk_in = ~sys_clk_in;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [8:0] est(input logic perr);
      return {1'b1, ~blink_off, perr, 6'h23};
   endfunction
   // display-side inputs and periodic end-of-line event
   always @(negedge sys_clk_in)
   begin
      cyc++;
      line_end <= (cyc % 40) < 4;
      if (cyc % 8 == 0)
         {attr, code, row} <= 19'(rnd() >> 5);
   end
   task automatic cmp_st(input logic [8:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_rg(input lhci_regs_t got, exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   initial forever
   begin
      @(host_u.seen);
      if (sq.size() > 0)
      begin
         es = sq.pop_front();
         cmp_st({doe, dout}, es);
      end
   end
   initial forever
   begin
      @(reg_ev);
      eg = rq.pop_front();
      cmp_rg(regs, eg);
   end
   task automatic note();
      host_u.wait_ready();
      rq.push_back(er);
      -> reg_ev;
   endtask
   task automatic cmd(input logic [7:0] k, a, d, input logic ops);
      if (ops)
      begin
         host_u.wr(1'b0, a ^ d ^ 8'h5A, 1'b0);
         host_u.wr(1'b0, a, 1'b0);
         host_u.wr(1'b0, d, 1'b0);
      end
      host_u.wr(1'b1, k, 1'b0);
      note();
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge sys_clk_in);
      rst_in = 1'b0;
      er = '0;
      note();
      for (int k = 0; k < 2; k++)
      begin
         blink_off = (k == 1);
         repeat (8) @(negedge sys_clk_in);
         sq.push_back(est(1'b0));
         host_u.rd();
      end
      $display("status test done");
      repeat (3) foreach (codes[i])
      begin
         r = rnd();
         c = codes[i];
         o1 = r[7:0];
         o2 = c inside {CMD_BANK_SET, CMD_TEXT_STRIDE, CMD_GFX_STRIDE} ? 8'h00 : r[15:8];
         case (c)
            CMD_CURSOR_SET:  {er.cursor_column, er.cursor_row} = {o1[6:0], o2[4:0]};
            CMD_BANK_SET:    er.cg_bank_bits = o1[4:0];
            CMD_POINTER_SET: er.ram_access_pointer = {o2, o1};
            CMD_TEXT_BASE:   er.text_base = {o2, o1};
            CMD_TEXT_STRIDE: er.text_stride = o1;
            CMD_GFX_BASE:    er.graphic_base = {o2, o1};
            default:         er.graphic_stride = o1;
         endcase
         cmd(c, o1, o2, 1'b1);
      end
      $display("register test done");
      foreach (modes[i])
      begin
         er.mode = modes[i];
         cmd({CMD_MODE_HI, modes[i]}, 8'h00, 8'h00, 1'b0);
         repeat (40) @(negedge sys_clk_in);
      end
      $display("mode test done");
      host_u.wr(1'b0, 8'h3C, 1'b1);
      host_u.wr(1'b1, CMD_CURSOR_SET, 1'b1);
      note();
      $display("deselect test done");
      clk_en = 1'b0;
      host_u.wr(1'b1, CMD_CURSOR_SET, 1'b0);
      repeat (4) @(negedge sys_clk_in);
      clk_en = 1'b1;
      note();
      $display("freeze test done");
      peek_fail = 1'b1;
      cmd(CMD_PEEK, 8'h00, 8'h00, 1'b0);
      sq.push_back(est(1'b1));
      host_u.rd();
      peek_fail = 1'b0;
      cmd(CMD_PEEK, 8'h00, 8'h00, 1'b0);
      sq.push_back(est(1'b0));
      host_u.rd();
      $display("error flag test done");
      for (int k = 0; k < 2; k++)
      begin
         host_u.wr(1'b1, k[0] ? CMD_AUTO_READ : CMD_AUTO_WRITE, 1'b0);
         host_u.auto_on = 1'b1;
         host_u.wait_ready();
         sq.push_back({1'b1, ~blink_off, 3'b010, ~k[0], k[0], 2'b00});
         host_u.rd();
         if (k == 0)
         begin
            host_u.wr(1'b0, 8'h11, 1'b0);
            er.ram_access_pointer = er.ram_access_pointer + 16'h0001;
         end
         host_u.wr(1'b1, CMD_AUTO_RESET, 1'b0);
         host_u.auto_on = 1'b0;
         note();
         sq.push_back(est(1'b0));
         host_u.rd();
      end
      $display("auto test done");
      end_sim();
   end
   initial
   begin
      repeat (40000) @(posedge sys_clk_in);
      miscompares++;
      end_sim();
   end
endmodule
